// ===== verilog/wwrc_top.sv
// Window watchdog, host reset, wake-up and data-ready control
// How it works
// - Trigger falling edge restarts watchdog by window
// - Initial window after reset, fault, sleep exit
// - Trigger inside closed window resets the host
// - Open window expiry resets the host
// - Standby or re-init leaves watchdog untouched
// - Sleep stops watchdog; sleep exit restarts initial
// - Trigger edge in sleep sets fault flag
// - Host reset idles high, pulses low
// - Wake edge in sleep/standby enters normal mode
// - Wake input debounced; host holds it low
// - Reset: normal mode, cleared data and flags
// - Reset: host reset high, ready after startup
// - Serial out released while chip select high
// - Re-init restores reset state except watchdog and mode
// - Re-init holds ready low for startup
// - Read-out end clears measurement data
// - Timeout pulses reset, reloads initial window
// - Mode change sets flags, keeps settings
// - Wake drops ready until exit delay
// - Measurement done raises ready for read-out
module wwrc_top
   import wwrc_pkg::*;
#(
   parameter int P_WDT_INIT = CYC_WDT_INIT,
   parameter int P_WDT_CLOSED = CYC_WDT_CLOSED,
   parameter int P_WDT_OPEN = CYC_WDT_OPEN,
   parameter int P_HOST_RESET = CYC_HOST_RESET,
   parameter int P_STARTUP = CYC_STARTUP,
   parameter int P_WAKE_SLP = CYC_WAKE_SLP,
   parameter int P_WAKE_STBY = CYC_WAKE_STBY
)
(
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_watchdog_trigger_input,
   input wire logic i_wake_request,
   input wire logic i_chip_select_n,
   input wire logic i_serial_data,
   input wire logic i_reinitialise_command,
   input wire logic i_sleep_command,
   input wire logic i_standby_command,
   input wire logic i_normal_running_mode,
   input wire logic i_start_measure_command,
   input wire logic i_measure_done,
   input wire logic i_read_out_done,
   input wire logic i_err_clear,
   input wire logic [7:0] i_meas_data,
   output logic o_master_reset_output,
   output logic o_data_ready_output,
   output logic o_serial_out,
   output logic o_serial_out_oe,
   output logic [7:0] o_meas_data,
   output logic [7:0] o_status_flags,
   output logic [7:0] o_fault_flags,
   output logic [7:0] o_user_settings,
   output logic [1:0] o_mode
);
   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = CNT_W'(n < 1 ? 1 : n);
   endfunction : cyc

   wwrc_mode_e mode_reg, mode_next;
   wwrc_win_e win_reg, win_next;
   logic wt_d_reg, wake_d_reg, wake_filt_reg, ready_reg;
   logic [7:0] meas_reg, stat_reg, err_reg, user_reg;
   logic [7:0] db_cnt_reg;
   logic mr_load, mr_zero, win_load, win_zero, rdy_load, rdy_zero;
   logic [CNT_W-1:0] win_value, rdy_value;
   logic ready_pending_reg;

   // Debounce: wake level must stay stable for the debounce time before it is believed
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         db_cnt_reg <= '0;
         wake_filt_reg <= 1'b1;
      end else if (i_wake_request == wake_filt_reg) begin
         db_cnt_reg <= '0;
      end else if (db_cnt_reg == 8'(CYC_DEBOUNCE - 1)) begin
         wake_filt_reg <= i_wake_request;
         db_cnt_reg <= '0;
      end else begin
         db_cnt_reg <= db_cnt_reg + 8'h01;
      end
   end

   logic wt_fall, wake_fall, wd_fault, wd_timeout, wd_early, sleep_exit, any_wake;
   assign wt_fall = wt_d_reg & ~i_watchdog_trigger_input;
   assign wake_fall = wake_d_reg & ~wake_filt_reg & (mode_reg != WWRC_MODE_NRM);
   assign sleep_exit = (mode_reg == WWRC_MODE_SLEEP) &
                       (wake_fall | i_normal_running_mode);
   assign any_wake = wake_fall | (i_normal_running_mode & mode_reg != WWRC_MODE_NRM);
   assign wd_early = wt_fall & (win_reg == WWRC_WIN_CLOSED);
   // The window counter is still empty on the first cycle after reset; that is no expiry
   assign wd_timeout = win_zero & ~ready_pending_reg &
                       (win_reg == WWRC_WIN_INIT || win_reg == WWRC_WIN_OPEN);
   assign wd_fault = (wd_early | wd_timeout) & (mode_reg != WWRC_MODE_SLEEP);

   always_comb begin
      mode_next = mode_reg;
      if (any_wake) mode_next = WWRC_MODE_NRM;
      else if (i_sleep_command) mode_next = WWRC_MODE_SLEEP;
      else if (i_standby_command) mode_next = WWRC_MODE_STBY;
   end

   // Window sequencer; standby and re-init deliberately have no path in here
   always_comb begin
      win_next = win_reg;
      win_load = 1'b0;
      win_value = cyc(P_WDT_INIT);
      if (mode_next == WWRC_MODE_SLEEP && !any_wake) begin
         win_next = WWRC_WIN_OFF;
      end else if (sleep_exit || wd_fault || ready_pending_reg) begin
         win_next = WWRC_WIN_INIT;
         win_load = 1'b1;
      end else if (wt_fall && win_reg != WWRC_WIN_OFF) begin
         win_next = WWRC_WIN_CLOSED;
         win_load = 1'b1;
         win_value = cyc(P_WDT_CLOSED);
      end else if (win_zero && win_reg == WWRC_WIN_CLOSED) begin
         win_next = WWRC_WIN_OPEN;
         win_load = 1'b1;
         win_value = cyc(P_WDT_OPEN);
      end
   end

   assign mr_load = wd_fault;
   assign o_master_reset_output = mr_zero;

   // Ready delay: startup after reset or re-init, exit delays after a wake
   always_comb begin
      rdy_load = 1'b0;
      rdy_value = cyc(P_STARTUP);
      if (i_reinitialise_command) begin
         rdy_load = 1'b1;
      end else if (any_wake) begin
         rdy_load = 1'b1;
         rdy_value = (mode_reg == WWRC_MODE_SLEEP) ? cyc(P_WAKE_SLP) : cyc(P_WAKE_STBY);
      end
   end

   wwrc_counter u_win (
      .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_load(win_load | i_sys_rst),
      .i_value(win_value), .o_zero(win_zero));
   wwrc_counter u_mr (
      .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_load(mr_load),
      .i_value(cyc(P_HOST_RESET)), .o_zero(mr_zero));
   wwrc_counter u_rdy (
      .i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_load(rdy_load | ready_pending_reg),
      .i_value(ready_pending_reg ? cyc(P_STARTUP) : rdy_value), .o_zero(rdy_zero));

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         mode_reg <= WWRC_MODE_NRM;
         win_reg <= WWRC_WIN_INIT;
         wt_d_reg <= 1'b1;
         wake_d_reg <= 1'b1;
         ready_pending_reg <= 1'b1;
      end else begin
         mode_reg <= mode_next;
         win_reg <= win_next;
         wt_d_reg <= i_watchdog_trigger_input;
         wake_d_reg <= wake_filt_reg;
         ready_pending_reg <= 1'b0;
      end
   end

   // Ready flag: low while any delay runs, high after it in normal mode or on measurement done
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) ready_reg <= 1'b0;
      else if (rdy_load || ready_pending_reg) ready_reg <= 1'b0;
      else if (i_start_measure_command) ready_reg <= 1'b0;
      else if (i_measure_done) ready_reg <= 1'b1;
      else if (rdy_zero && !o_data_ready_output && mode_reg == WWRC_MODE_NRM &&
               $past(!rdy_zero)) ready_reg <= 1'b1;
   end
   assign o_data_ready_output = ready_reg;

   // Data and flag registers; watchdog and mode state stay out of re-init
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst || i_reinitialise_command) begin
         meas_reg <= MEAS_RESET;
         stat_reg <= 8'h00;
         err_reg <= ERR_RESET;
         user_reg <= USER_DEFAULT;
      end else begin
         if (i_read_out_done) meas_reg <= MEAS_RESET;
         else if (i_measure_done) meas_reg <= i_meas_data;
         if (mode_next != mode_reg) begin
            stat_reg <= stat_reg & ~8'h07;
            stat_reg[STAT_NRM_BIT] <= (mode_next == WWRC_MODE_NRM);
            stat_reg[STAT_STBY_BIT] <= (mode_next == WWRC_MODE_STBY);
            stat_reg[STAT_SLEEP_BIT] <= (mode_next == WWRC_MODE_SLEEP);
         end
         // Set wins over the error clear, so a sleep trigger is lost only to a re-init in the same cycle
         if (wt_fall && mode_reg == WWRC_MODE_SLEEP) err_reg[ERR_WT_SLEEP_BIT] <= 1'b1;
         else if (i_err_clear) err_reg[ERR_WT_SLEEP_BIT] <= 1'b0;
      end
   end

   assign o_serial_out_oe = ~i_chip_select_n;
   assign o_serial_out = i_serial_data;
   assign o_meas_data = meas_reg;
   assign o_status_flags = stat_reg;
   assign o_fault_flags = err_reg;
   assign o_user_settings = user_reg;
   assign o_mode = mode_reg;

   property p_early_reset;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (wt_fall && win_reg == WWRC_WIN_CLOSED && mode_reg != WWRC_MODE_SLEEP)
         |=> !o_master_reset_output;
   endproperty
   a_early_reset: assert property (p_early_reset) else $error("no reset on early trigger");

   property p_timeout_reset;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (win_zero && win_reg == WWRC_WIN_OPEN && mode_reg != WWRC_MODE_SLEEP)
         |=> !o_master_reset_output ##0 win_reg == WWRC_WIN_INIT;
   endproperty
   a_timeout_reset: assert property (p_timeout_reset) else $error("no reset on timeout");

   property p_sleep_off;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (mode_reg == WWRC_MODE_SLEEP && !any_wake) |=> win_reg == WWRC_WIN_OFF;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("watchdog runs in sleep");

   property p_sleep_err;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (wt_fall && mode_reg == WWRC_MODE_SLEEP && !i_reinitialise_command)
         |=> o_fault_flags[ERR_WT_SLEEP_BIT];
   endproperty
   a_sleep_err: assert property (p_sleep_err) else $error("sleep trigger not flagged");

   property p_retrigger;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (wt_fall && win_reg == WWRC_WIN_OPEN && mode_reg != WWRC_MODE_SLEEP && !any_wake)
         |=> win_reg == WWRC_WIN_CLOSED && o_master_reset_output;
   endproperty
   a_retrigger: assert property (p_retrigger) else $error("retrigger not taken");

   property p_wake_nrm;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         wake_fall |=> mode_reg == WWRC_MODE_NRM && !o_data_ready_output;
   endproperty
   a_wake_nrm: assert property (p_wake_nrm) else $error("wake not handled");

   property p_reinit_keep;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (i_reinitialise_command && !wd_fault && !wt_fall && !win_zero && !any_wake &&
          !i_sleep_command) |=> win_reg == $past(win_reg) && !o_data_ready_output;
   endproperty
   a_reinit_keep: assert property (p_reinit_keep) else $error("re-init touched watchdog");

   property p_readout_clear;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         i_read_out_done |=> o_meas_data == MEAS_RESET;
   endproperty
   a_readout_clear: assert property (p_readout_clear) else $error("data not cleared");

   property p_reset_lines;
      @(posedge i_sys_clk) i_sys_rst |=> o_master_reset_output && !o_data_ready_output;
   endproperty
   a_reset_lines: assert property (p_reset_lines) else $error("reset lines wrong");

   property p_reset_state;
      @(posedge i_sys_clk) i_sys_rst |=> o_mode == WWRC_MODE_NRM &&
         o_fault_flags == ERR_RESET && o_user_settings == USER_DEFAULT &&
         o_meas_data == MEAS_RESET;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

   property p_fault_load;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (mr_load && !i_sleep_command) |=> !o_master_reset_output && win_reg == WWRC_WIN_INIT;
   endproperty
   a_fault_load: assert property (p_fault_load) else $error("fault not handled");

   property p_mr_cause;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         $fell(o_master_reset_output) |-> $past(wd_fault);
   endproperty
   a_mr_cause: assert property (p_mr_cause) else $error("host reset without fault");

   property p_measure_capture;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (i_measure_done && !i_read_out_done && !i_reinitialise_command && !any_wake &&
          !i_start_measure_command && !ready_pending_reg)
         |=> o_meas_data == $past(i_meas_data) && o_data_ready_output;
   endproperty
   a_measure_capture: assert property (p_measure_capture) else $error("no capture");

   property p_start_drop;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         i_start_measure_command |=> !o_data_ready_output;
   endproperty
   a_start_drop: assert property (p_start_drop) else $error("ready kept on start");

   property p_reinit_clear;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         i_reinitialise_command |=> o_meas_data == MEAS_RESET &&
         o_fault_flags == ERR_RESET && o_user_settings == USER_DEFAULT;
   endproperty
   a_reinit_clear: assert property (p_reinit_clear) else $error("re-init kept data");

   property p_serial_off;
      @(posedge i_sys_clk) i_chip_select_n |-> !o_serial_out_oe;
   endproperty
   a_serial_off: assert property (p_serial_off) else $error("serial out driven");

   property p_mode_flags;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (mode_next != mode_reg && !i_reinitialise_command) |=>
         o_status_flags[STAT_NRM_BIT] == (o_mode == WWRC_MODE_NRM) &&
         o_status_flags[STAT_STBY_BIT] == (o_mode == WWRC_MODE_STBY) &&
         o_status_flags[STAT_SLEEP_BIT] == (o_mode == WWRC_MODE_SLEEP);
   endproperty
   a_mode_flags: assert property (p_mode_flags) else $error("mode flags wrong");

   property p_mode_keep;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (mode_next != mode_reg && !i_reinitialise_command) |=> $stable(o_user_settings);
   endproperty
   a_mode_keep: assert property (p_mode_keep) else $error("settings lost on mode");

   property p_stby_keep;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (i_standby_command && mode_reg == WWRC_MODE_NRM && !i_sleep_command && !wt_fall &&
          !win_zero && !ready_pending_reg) |=> win_reg == $past(win_reg);
   endproperty
   a_stby_keep: assert property (p_stby_keep) else $error("standby moved watchdog");

   property p_sleep_exit;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         sleep_exit |=> win_reg == WWRC_WIN_INIT && o_mode == WWRC_MODE_NRM;
   endproperty
   a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit no init");

   property p_err_clear;
      @(posedge i_sys_clk) disable iff (i_sys_rst)
         (i_err_clear && !(wt_fall && mode_reg == WWRC_MODE_SLEEP))
         |=> !o_fault_flags[ERR_WT_SLEEP_BIT];
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("fault flag not cleared");
endmodule : wwrc_top

// ===== verilog/wwrc_pkg.sv
// Constants and types shared by the window watchdog and reset control block
package wwrc_pkg;
   localparam real CLK_MHZ = 40.0;
   // Window and pulse times in microseconds, debounce time in nanoseconds; cycle counts derive from the clock rate
   localparam int T_WDT_INIT_US = 100;
   localparam int T_WDT_CLOSED_US = 50;
   localparam int T_WDT_OPEN_US = 50;
   localparam int T_HOST_RESET_US = 10;
   localparam int T_STARTUP_US = 20;
   localparam int T_WAKE_SLP_US = 20;
   localparam int T_WAKE_STBY_US = 5;
   localparam int T_DEBOUNCE_NS = 2000;
   localparam int CYC_WDT_INIT = T_WDT_INIT_US * 40;
   localparam int CYC_WDT_CLOSED = T_WDT_CLOSED_US * 40;
   localparam int CYC_WDT_OPEN = T_WDT_OPEN_US * 40;
   localparam int CYC_HOST_RESET = T_HOST_RESET_US * 40;
   localparam int CYC_STARTUP = T_STARTUP_US * 40;
   localparam int CYC_WAKE_SLP = T_WAKE_SLP_US * 40;
   localparam int CYC_WAKE_STBY = T_WAKE_STBY_US * 40;
   localparam int CYC_DEBOUNCE = T_DEBOUNCE_NS / 25;
   localparam int CNT_W = 16;
   localparam logic [7:0] MEAS_RESET = 8'h00;
   localparam logic [7:0] ERR_RESET = 8'h00;
   localparam logic [7:0] STAT_CLR_MASK = 8'h98;
   localparam logic [7:0] USER_DEFAULT = 8'h02;
   localparam int ERR_WT_SLEEP_BIT = 0;
   localparam int STAT_STBY_BIT = 1;
   localparam int STAT_SLEEP_BIT = 2;
   localparam int STAT_NRM_BIT = 0;
   typedef enum logic [1:0] {WWRC_MODE_NRM, WWRC_MODE_STBY, WWRC_MODE_SLEEP} wwrc_mode_e;
   typedef enum logic [1:0] {WWRC_WIN_INIT, WWRC_WIN_CLOSED, WWRC_WIN_OPEN, WWRC_WIN_OFF}
      wwrc_win_e;
endpackage : wwrc_pkg

// ===== verilog/wwrc_counter.sv
// Down counter with load, used for the window, host reset and ready delays
module wwrc_counter
   import wwrc_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_load,
   input wire logic [CNT_W-1:0] i_value,
   output logic o_zero
);
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;
   assign cnt_next = i_load ? i_value : (cnt_reg != '0 ? cnt_reg - 1'b1 : cnt_reg);
   assign o_zero = (cnt_reg == '0);
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) cnt_reg <= '0;
      else cnt_reg <= cnt_next;
   end
endmodule : wwrc_counter

// ===== testbench/wwrc_host_model.sv
// Host microcontroller model that retriggers the watchdog
module wwrc_host_model #(
   parameter int P_TRIG_LOW = 3
)
(
   input wire logic i_clk,
   input wire logic i_fire,
   output logic o_trigger
);
   timeunit 1ns;
   timeprecision 1ps;
   int low_cnt = 0;
   initial o_trigger = 1'b1;
   // A second request during the low phase is ignored, so the minimum is never cut
   always @(posedge i_clk) begin
      if (i_fire && low_cnt == 0) low_cnt = P_TRIG_LOW;
      if (low_cnt > 0) begin
         o_trigger <= 1'b0;
         low_cnt = low_cnt - 1;
      end else begin
         o_trigger <= 1'b1;
      end
   end
endmodule : wwrc_host_model

// ===== testbench/tb_top.sv
// Self-checking bench for the window watchdog and reset control block
module tb_top import wwrc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int P_INIT = 60;
   localparam int P_HR = 4;
   localparam int P_ST = 8;
   localparam int P_WB = 4;
   logic clk, rst, wake, cs_n, sdata, fire, mr, rdy, so, soe;
   logic [7:0] cmd, mdata, mo, st, ft, us;
   logic [1:0] mode;
   wire trig;
   int seed = 32'h2bd2;
   int fails = 0;
   int comparisons = 0;
   int exp_q[$];
   int wid = 0;
   int n;
   wwrc_host_model #(.P_TRIG_LOW(3)) i_host (.i_clk(clk), .i_fire(fire), .o_trigger(trig));
   wwrc_top #(.P_WDT_INIT(P_INIT), .P_WDT_CLOSED(20), .P_WDT_OPEN(20), .P_HOST_RESET(P_HR),
      .P_STARTUP(P_ST), .P_WAKE_SLP(8), .P_WAKE_STBY(P_WB)) i_dut (
      .i_sys_clk(clk), .i_sys_rst(rst), .i_watchdog_trigger_input(trig),
      .i_wake_request(wake), .i_chip_select_n(cs_n), .i_serial_data(sdata),
      .i_reinitialise_command(cmd[0]), .i_sleep_command(cmd[1]), .i_standby_command(cmd[2]),
      .i_normal_running_mode(cmd[3]), .i_start_measure_command(cmd[4]),
      .i_measure_done(cmd[5]), .i_read_out_done(cmd[6]), .i_err_clear(cmd[7]),
      .i_meas_data(mdata), .o_master_reset_output(mr), .o_data_ready_output(rdy),
      .o_serial_out(so), .o_serial_out_oe(soe), .o_meas_data(mo), .o_status_flags(st),
      .o_fault_flags(ft), .o_user_settings(us), .o_mode(mode));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task conclude;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   task send(input int b);
      @(negedge clk) cmd = 8'(1 << b);
      @(negedge clk) cmd = 8'h00;
   endtask : send
   task fire_trig;
      @(negedge clk) fire = 1'b1;
      @(negedge clk) fire = 1'b0;
   endtask : fire_trig
   task wait_sig(input int hi, input logic want_mr);
      n = 0;
      while ((want_mr ? mr !== 1'b0 : rdy !== 1'b1) && n < hi) begin
         @(negedge clk);
         n++;
      end
      if (n >= hi) begin
         fails++;
         $display("BAD %0t wait ran out", $time);
         conclude();
      end
   endtask : wait_sig
   // Pulse width is judged by the monitor; here only the moment it starts
   task wait_mr(input int lo, input int hi);
      exp_q.push_back(P_HR);
      wait_sig(hi, 1'b1);
      check(n >= lo, 1'b1);
      repeat (P_HR + 2) @(negedge clk);
   endtask : wait_mr
   task wake_up;
      int lowc;
      lowc = 0;
      @(negedge clk) wake = 1'b0;
      for (int i = 0; i < 100; i++) begin
         @(negedge clk);
         if (rdy === 1'b0) lowc++;
         // Released early so the filter is high again before the next wake
         if (i == 90) wake = 1'b1;
      end
      check(mode, WWRC_MODE_NRM);
      check(lowc >= P_WB, 1'b1);
   endtask : wake_up
   // Every low pulse must match the oldest expectation; an unexpected one meets width 0
   always @(negedge clk) begin
      if (mr === 1'b0) wid++;
      else if (wid > 0) begin
         if (exp_q.size() == 0) check(wid, 0);
         else check(wid, exp_q.pop_front());
         wid = 0;
      end
   end
   initial begin
      rst = 1'b1; wake = 1'b1; cs_n = 1'b1; sdata = 1'b0; fire = 1'b0;
      cmd = 8'h00; mdata = 8'h00;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check(mr, 1'b1);
      check(rdy, 1'b0);
      check(mode, WWRC_MODE_NRM);
      check(ft, ERR_RESET);
      check(us, USER_DEFAULT);
      check(mo, MEAS_RESET);
      check(st & STAT_CLR_MASK, 8'h00);
      wait_sig(30, 1'b0);
      check(n >= P_ST, 1'b1);
      for (int i = 0; i < 3; i++) begin
         send(4);
         check(rdy, 1'b0);
         @(negedge clk) {cs_n, sdata, mdata} = 10'($random(seed));
         send(5);
         check(mo, mdata);
         check(rdy, 1'b1);
         check(soe, !cs_n);
         if (!cs_n) check(so, sdata);
         send(6);
         check(mo, MEAS_RESET);
      end
      wait_mr(20, 50);
      fire_trig();
      repeat (6) @(negedge clk);
      fire_trig();
      wait_mr(0, 12);
      fire_trig();
      repeat (5) @(negedge clk);
      send(0);
      check(rdy, 1'b0);
      wait_sig(20, 1'b0);
      repeat (8) @(negedge clk);
      fire_trig();
      send(0);
      wait_mr(33, 46);
      send(1);
      check(mode, WWRC_MODE_SLEEP);
      check(st[STAT_SLEEP_BIT], 1'b1);
      fire_trig();
      repeat (3) @(negedge clk);
      check(ft[ERR_WT_SLEEP_BIT], 1'b1);
      send(7);
      check(ft[ERR_WT_SLEEP_BIT], 1'b0);
      wake_up();
      wait_mr(30, 50);
      repeat (30) @(negedge clk);
      // Watchdog keeps running through standby: two expiries fall inside the next steps
      exp_q.push_back(P_HR);
      exp_q.push_back(P_HR);
      send(2);
      check(mode, WWRC_MODE_STBY);
      wake_up();
      repeat (10) @(negedge clk);
      check(exp_q.size(), 0);
      conclude();
   end
endmodule : tb_top
